// ==== adc_cmd_pkg.sv ====
package adc_cmd_pkg;

  // ****************************************
  // Register byte addresses (index times four)
  // ****************************************
  localparam logic [7:0] IDX_LIST_END_INFO = 8'h10;
  localparam logic [7:0] IDX_CMD_BYTE0     = 8'h14;
  localparam logic [7:0] IDX_CMD_BYTE1     = 8'h15;
  localparam logic [7:0] ADDR_CONTROL      = 8'h00;
  localparam logic [7:0] ADDR_FLAGS        = 8'h30;
  localparam logic [7:0] ADDR_LIST_END_INFO = {IDX_LIST_END_INFO[5:0], 2'b00};
  localparam logic [7:0] ADDR_CMD_BYTE0    = {IDX_CMD_BYTE0[5:0], 2'b00};
  localparam logic [7:0] ADDR_CMD_BYTE1    = {IDX_CMD_BYTE1[5:0], 2'b00};
  localparam logic [7:0] ADDR_STATUS       = 8'h60;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_ENABLE_BIT      = 0;
  localparam int CTL_SOFT_RESET_BIT  = 1;
  localparam int CTL_SPECIAL_BIT     = 2;
  localparam int CTL_RESTART_BIT     = 3;
  localparam int INFO_LIST_BIT       = 7;
  localparam int INFO_BUFFER_BIT     = 6;
  localparam int CMD_TYPE_HI         = 15;
  localparam int CMD_TYPE_LO         = 14;
  localparam int CMD_RSVD_HI         = 13;
  localparam int CMD_RSVD_LO         = 12;
  localparam int CMD_FLAG_HI         = 11;
  localparam int CMD_FLAG_LO         = 8;
  localparam int CMD_HIGH_REF_BIT    = 7;
  localparam int CMD_LOW_REF_BIT     = 6;
  localparam int CMD_CHAN_HI         = 5;
  localparam int CMD_CHAN_LO         = 0;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [3:0]  CONTROL_RESET   = 4'h0;
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  localparam logic [15:0] FLAGS_RESET     = 16'h0000;
  localparam logic [1:0]  INFO_RESET      = 2'h0;
  localparam logic [4:0]  EXT_INPUT_COUNT = 5'h10;

  // ****************************************
  // Command types and channel codes
  // ****************************************
  localparam logic [1:0] CMD_NORMAL      = 2'h0;
  localparam logic [1:0] CMD_END_SEQ     = 2'h1;
  localparam logic [1:0] CMD_END_LIST    = 2'h2;
  localparam logic [1:0] CMD_END_LIST_WT = 2'h3;
  localparam logic [5:0] CHAN_FIRST_RSVD = 6'h03;
  localparam logic [5:0] CHAN_LAST_RSVD  = 6'h07;

  typedef enum logic [2:0] {
    ST_WAIT_TRIG    = 3'h0,
    ST_FETCH        = 3'h1,
    ST_CONVERT      = 3'h3,
    ST_WAIT_RESTART = 3'h2,
    ST_HALT         = 3'h6
  } seq_state_type;

endpackage

// ==== adc_command_decode_eol_info.sv ====
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
// Summary of operation
// - Disable or soft reset clears the list-end information register.
// - List-end information reads anytime; writes are ignored.
// - Bit 7 records active command list when list-end result is stored.
// - Bit 6 records active result buffer when list-end result is stored.
// - Information updates in the same cycle the list-end flag sets.
// - Command bytes read anytime; writable only with special-mode access.
// - Command type 00 is normal; sequencer fetches the next command.
// - Type 01 ends sequence; wait for trigger or restart.
// - Type 10 wraps to list top and continues without waiting.
// - Type 11 wraps; restart mode waits restart then trigger.
// - Flag select zero sets no conversion flag at conversion end.
// - Flag select n sets exactly conversion flag n.
// - Reserved command fields set command error and halt conversions.
// - Command bit 7 picks high reference input 0 or 1.
// - Command bit 6 picks low reference input 0 or 1.
// - Channel codes 0,1,2 pick low ref, high ref, midpoint.
// - Codes 3 to 7 reserved; 8 to 15 internal sources.
// - Codes 01xxxx external inputs; top bit set is reserved.
// - List-end flag sets only for list-end types after result stored.
// - Flags clear on write one; zero or no write never sets.
module adc_command_decode_eol_info
  import adc_cmd_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_clock_enable,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_trigger,
  input  wire logic        i_restart,
  input  wire logic        i_cmd_load,
  input  wire logic [15:0] i_cmd_word,
  input  wire logic        i_conv_done,
  input  wire logic        i_active_list,
  input  wire logic        i_active_buffer,
  output logic             o_fetch_req,
  output logic             o_conv_start,
  output logic             o_list_wrap,
  output logic             o_high_ref_sel,
  output logic             o_low_ref_sel,
  output logic      [5:0]  o_channel_sel,
  output logic      [15:0] o_flags,
  output logic             o_cmd_error
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [3:0]    control_r;
  logic [15:0]   cmd_r;
  logic [15:0]   flags_r;
  logic [1:0]    info_r;
  logic          cmd_error_r;
  seq_state_type state_r;
  seq_state_type state_nxt;
  logic          fetch_nxt;
  logic          start_nxt;
  logic          wrap_nxt;
  logic          pready_r;
  logic          pslverr_r;
  logic [31:0]   prdata_r;
  logic [31:0]   rdata_nxt;
  logic          mapped;
  logic          wr_en;
  logic          clear_all;
  logic          load_bad;
  logic          list_end_done;
  logic [15:0]   flag_set;
  logic [1:0]    cmd_type;

  assign wr_en     = psel & penable & pready_r & pwrite & i_clock_enable;
  assign clear_all = control_r[CTL_SOFT_RESET_BIT]
                   | ~control_r[CTL_ENABLE_BIT];
  assign cmd_type  = cmd_r[CMD_TYPE_HI:CMD_TYPE_LO];

  // ****************************************
  // Reserved field check on fetched command
  // ****************************************
  always_comb begin
    logic [5:0] chan;
    chan     = i_cmd_word[CMD_CHAN_HI:CMD_CHAN_LO];
    load_bad = 1'b0;
    if (i_cmd_word[CMD_RSVD_HI:CMD_RSVD_LO] != 2'h0) begin
      load_bad = 1'b1;
    end
    if (chan >= CHAN_FIRST_RSVD && chan <= CHAN_LAST_RSVD) begin
      load_bad = 1'b1;
    end
    if (chan[5] || (chan[4] && {1'b0, chan[3:0]} >= EXT_INPUT_COUNT)) begin
      load_bad = 1'b1;
    end
  end

  // ****************************************
  // APB slave timing
  // ****************************************
  always_comb begin
    mapped    = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      ADDR_CONTROL: begin
        rdata_nxt[3:0] = control_r;
      end
      ADDR_FLAGS: begin
        rdata_nxt[15:0] = flags_r;
      end
      ADDR_LIST_END_INFO: begin
        rdata_nxt[INFO_LIST_BIT]   = info_r[1];
        rdata_nxt[INFO_BUFFER_BIT] = info_r[0];
      end
      ADDR_CMD_BYTE0: begin
        rdata_nxt[7:0] = cmd_r[15:8];
      end
      ADDR_CMD_BYTE1: begin
        rdata_nxt[7:0] = cmd_r[7:0];
      end
      ADDR_STATUS: begin
        rdata_nxt[0]   = cmd_error_r;
        rdata_nxt[4:2] = state_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (i_clock_enable) begin
      pready_r  <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      control_r <= CONTROL_RESET;
    end else if (wr_en && paddr == ADDR_CONTROL) begin
      control_r <= pwdata[3:0];
    end
  end

  // ****************************************
  // Command register
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cmd_r <= CMD_RESET;
    end else if (i_clock_enable) begin
      if (i_cmd_load && state_r == ST_FETCH) begin
        cmd_r <= i_cmd_word;
      end else if (wr_en && control_r[CTL_SPECIAL_BIT]) begin
        if (paddr == ADDR_CMD_BYTE0) begin
          cmd_r[15:8] <= pwdata[7:0];
        end
        if (paddr == ADDR_CMD_BYTE1) begin
          cmd_r[7:0] <= pwdata[7:0];
        end
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    fetch_nxt = 1'b0;
    start_nxt = 1'b0;
    wrap_nxt  = 1'b0;
    case (state_r)
      ST_WAIT_TRIG: begin
        if (i_trigger || i_restart) begin
          state_nxt = ST_FETCH;
          fetch_nxt = 1'b1;
          wrap_nxt  = i_restart;
        end
      end
      ST_FETCH: begin
        if (i_cmd_load) begin
          if (load_bad) begin
            state_nxt = ST_HALT;
          end else begin
            state_nxt = ST_CONVERT;
            start_nxt = 1'b1;
          end
        end
      end
      ST_CONVERT: begin
        if (i_conv_done) begin
          case (cmd_type)
            CMD_NORMAL: begin
              state_nxt = ST_FETCH;
              fetch_nxt = 1'b1;
            end
            CMD_END_SEQ: begin
              state_nxt = ST_WAIT_TRIG;
            end
            CMD_END_LIST: begin
              state_nxt = ST_FETCH;
              fetch_nxt = 1'b1;
              wrap_nxt  = 1'b1;
            end
            default: begin
              wrap_nxt  = 1'b1;
              state_nxt = control_r[CTL_RESTART_BIT] ? ST_WAIT_RESTART
                                                     : ST_WAIT_TRIG;
            end
          endcase
        end
      end
      ST_WAIT_RESTART: begin
        if (i_restart) begin
          state_nxt = ST_WAIT_TRIG;
        end
      end
      ST_HALT: begin
        state_nxt = ST_HALT;
      end
      default: begin
        state_nxt = ST_WAIT_TRIG;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r      <= ST_WAIT_TRIG;
      o_fetch_req  <= 1'b0;
      o_conv_start <= 1'b0;
      o_list_wrap  <= 1'b0;
    end else if (i_clock_enable) begin
      if (clear_all) begin
        state_r      <= ST_WAIT_TRIG;
        o_fetch_req  <= 1'b0;
        o_conv_start <= 1'b0;
        o_list_wrap  <= 1'b0;
      end else begin
        state_r      <= state_nxt;
        o_fetch_req  <= fetch_nxt;
        o_conv_start <= start_nxt;
        o_list_wrap  <= wrap_nxt;
      end
    end
  end

  // ****************************************
  // Command error flag
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cmd_error_r <= 1'b0;
    end else if (i_clock_enable) begin
      if (clear_all) begin
        cmd_error_r <= 1'b0;
      end else if (state_r == ST_FETCH && i_cmd_load && load_bad) begin
        cmd_error_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  assign list_end_done = state_r == ST_CONVERT && i_conv_done
                       && cmd_type[1] && !clear_all;

  assign flag_set[0] = list_end_done;

  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++) begin : g_flag
      assign flag_set[gi] = state_r == ST_CONVERT && i_conv_done
                 && cmd_r[CMD_FLAG_HI:CMD_FLAG_LO] == 4'(gi);
      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          flags_r[gi] <= FLAGS_RESET[gi];
        end else if (i_clock_enable) begin
          if (clear_all) begin
            flags_r[gi] <= 1'b0;
          end else if (flag_set[gi]) begin
            flags_r[gi] <= 1'b1;
          end else if (wr_en && paddr == ADDR_FLAGS && pwdata[gi]) begin
            flags_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      flags_r[0] <= FLAGS_RESET[0];
    end else if (i_clock_enable) begin
      if (clear_all) begin
        flags_r[0] <= 1'b0;
      end else if (flag_set[0]) begin
        flags_r[0] <= 1'b1;
      end else if (wr_en && paddr == ADDR_FLAGS && pwdata[0]) begin
        flags_r[0] <= 1'b0;
      end
    end
  end

  // ****************************************
  // List-end information
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      info_r <= INFO_RESET;
    end else if (i_clock_enable) begin
      // cleared when off or soft reset
      if (clear_all) begin
        info_r <= INFO_RESET;
      end else if (list_end_done) begin
        info_r <= {i_active_list, i_active_buffer};
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_prdata  = prdata_r;
  assign o_pready  = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_high_ref_sel = cmd_r[CMD_HIGH_REF_BIT];
  assign o_low_ref_sel  = cmd_r[CMD_LOW_REF_BIT];
  assign o_channel_sel  = cmd_r[CMD_CHAN_HI:CMD_CHAN_LO];
  assign o_flags        = flags_r;
  assign o_cmd_error    = cmd_error_r;

endmodule

// ==== adc_command_decode_eol_info_asserts.sv ====
`timescale 1ns/100ps
module adc_command_decode_eol_info_asserts
  import adc_cmd_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_clock_enable,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        o_pready,
  input  wire logic        i_trigger,
  input  wire logic        i_restart,
  input  wire logic        i_cmd_load,
  input  wire logic        i_conv_done,
  input  wire logic        o_fetch_req,
  input  wire logic        o_conv_start,
  input  wire logic        o_list_wrap,
  input  wire logic [15:0] o_flags,
  input  wire logic        o_cmd_error
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // ****************************************
  // Newly raised flags
  // ****************************************
  logic [15:0] prev_flags_r;
  logic [15:0] rise_flags;
  always_ff @(posedge i_clock) begin
    prev_flags_r <= o_flags;
  end
  assign rise_flags = o_flags & ~prev_flags_r;

  // ****************************************
  // Checks
  // ****************************************
  a_ready_after_setup: assert property (
    psel && !penable && i_clock_enable |=> o_pready)
    else $error("no ready after setup phase");
  a_conv_flag_cause: assert property (
    rise_flags[15:1] != 15'h0 |-> $past(i_conv_done))
    else $error("conversion flag raised without done");
  a_one_flag_only: assert property (
    $onehot0(rise_flags[15:1]))
    else $error("more than one conversion flag raised");
  a_list_end_cause: assert property (
    $rose(o_flags[0]) |-> $past(i_conv_done) && o_list_wrap)
    else $error("list end flag without done and wrap");
  a_error_cause: assert property (
    $rose(o_cmd_error) |-> $past(i_cmd_load))
    else $error("command error without a command");
  a_halt_quiet: assert property (
    o_cmd_error |-> !o_conv_start && !o_fetch_req)
    else $error("activity while halted");
  a_start_cause: assert property (
    o_conv_start |-> $past(i_cmd_load))
    else $error("start without command");
  a_fetch_cause: assert property (
    o_fetch_req |-> $past(i_trigger || i_restart || i_conv_done))
    else $error("fetch without cause");
  a_disable_clears: assert property (
    psel && penable && pwrite && o_pready && paddr == ADDR_CONTROL
    && (!pwdata[0] || pwdata[1])
    |-> ##[1:2] (o_flags == 16'h0000 && !o_cmd_error))
    else $error("disable or soft reset left state");
endmodule

bind adc_command_decode_eol_info adc_command_decode_eol_info_asserts chk_u (
  .i_clock, .i_reset, .i_clock_enable, .psel, .penable, .pwrite, .paddr,
  .pwdata, .o_pready, .i_trigger, .i_restart, .i_cmd_load, .i_conv_done,
  .o_fetch_req, .o_conv_start, .o_list_wrap, .o_flags, .o_cmd_error);

// ==== adc_command_decode_eol_info_tb.sv ====
`timescale 1ns/100ps
module adc_command_decode_eol_info_tb
  import adc_cmd_pkg::*;
;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_clock_enable = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, o_prdata, rdata;
  logic        o_pready, o_pslverr, last_err;
  logic        i_trigger = 1'b0, i_restart = 1'b0, i_cmd_load = 1'b0;
  logic        i_conv_done = 1'b0, i_active_list = 1'b0;
  logic        i_active_buffer = 1'b0;
  logic [15:0] i_cmd_word = 16'h0000, o_flags;
  logic        o_fetch_req, o_conv_start, o_list_wrap;
  logic        o_high_ref_sel, o_low_ref_sel, o_cmd_error;
  logic [5:0]  o_channel_sel;
  int          fail_count = 0, tests_run = 0;

  always #25 i_clock = ~i_clock;

  adc_command_decode_eol_info dut_u (
    .i_clock, .i_reset, .i_clock_enable, .psel, .penable, .pwrite,
    .paddr, .pwdata, .o_prdata, .o_pready, .o_pslverr, .i_trigger,
    .i_restart, .i_cmd_load, .i_cmd_word, .i_conv_done, .i_active_list,
    .i_active_buffer, .o_fetch_req, .o_conv_start, .o_list_wrap,
    .o_high_ref_sel, .o_low_ref_sel, .o_channel_sel, .o_flags, .o_cmd_error);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic step;
    @(posedge i_clock);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    step;
    penable <= 1'b1;
    do begin
      step;
    end while (o_pready !== 1'b1);
    rdata    = o_prdata;
    last_err = o_pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    step;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic pulse(input logic [2:0] ev);
    {i_trigger, i_restart, i_conv_done} <= ev;
    step;
    {i_trigger, i_restart, i_conv_done} <= 3'h0;
    step;
  endtask

  task automatic load(input logic [15:0] w);
    i_cmd_load <= 1'b1;
    i_cmd_word <= w;
    step;
    i_cmd_load <= 1'b0;
    i_cmd_word <= ~w;
    step;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    apb(1'b0, ADDR_LIST_END_INFO, 32'h0);
    check(rdata, 32'h0, "info after reset");
    apb(1'b0, ADDR_CMD_BYTE0, 32'h0);
    check(rdata, 32'h0, "command after reset");
    apb(1'b0, 8'h20, 32'h0);
    check(last_err, 1'b1, "unmapped address");
    $display("test regs done");
  endtask

  task automatic t_cmd_access;
    apb(1'b1, ADDR_CONTROL, 32'h1);
    apb(1'b1, ADDR_CMD_BYTE0, 32'hFF);
    apb(1'b0, ADDR_CMD_BYTE0, 32'h0);
    check(rdata, 32'h0, "locked command write");
    apb(1'b1, ADDR_CONTROL, 32'h5);
    apb(1'b1, ADDR_CMD_BYTE1, 32'h90);
    apb(1'b0, ADDR_CMD_BYTE1, 32'h0);
    check(rdata, 32'h90, "special command write");
    apb(1'b1, ADDR_CONTROL, 32'h1);
    $display("test command access done");
  endtask

  task automatic t_freeze;
    i_clock_enable <= 1'b0;
    pulse(3'h4);
    check(o_fetch_req, 1'b0, "trigger while frozen");
    i_clock_enable <= 1'b1;
    step;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rdata, 32'h0, "state held while frozen");
    $display("test freeze done");
  endtask

  task automatic t_list_end;
    i_active_list   <= 1'b1;
    i_active_buffer <= 1'b0;
    pulse(3'h4);
    check(o_fetch_req, 1'b1, "fetch on trigger");
    load(16'h8110);
    check(o_conv_start, 1'b1, "start");
    check(o_channel_sel, 6'h10, "external input");
    pulse(3'h1);
    check(o_flags, 16'h0003, "list end flags");
    check({o_list_wrap, o_fetch_req}, 2'h3, "wrap and go on");
    apb(1'b0, ADDR_LIST_END_INFO, 32'h0);
    check(rdata, 32'h80, "list bit");
    apb(1'b1, ADDR_LIST_END_INFO, 32'hFF);
    apb(1'b0, ADDR_LIST_END_INFO, 32'h0);
    check(rdata, 32'h80, "info read only");
    apb(1'b1, ADDR_FLAGS, 32'h1);
    check(o_flags, 16'h0002, "clear by one");
    apb(1'b1, ADDR_FLAGS, 32'h0);
    check(o_flags, 16'h0002, "zero write keeps");
    apb(1'b1, ADDR_FLAGS, 32'h2);
    load(16'h4FC8);
    check({o_high_ref_sel, o_low_ref_sel}, 2'h3, "refs");
    check(o_channel_sel, 6'h08, "internal source");
    pulse(3'h1);
    check(o_flags, 16'h8000, "flag fifteen");
    check(o_fetch_req, 1'b0, "sequence end waits");
    apb(1'b1, ADDR_FLAGS, 32'h8000);
    $display("test list end done");
  endtask

  task automatic t_flag_sel;
    logic [15:0] exp;
    i_active_list   <= 1'b0;
    i_active_buffer <= 1'b1;
    pulse(3'h4);
    for (int n = 0; n < 16; n++) begin
      load({((n == 15) ? 2'h2 : 2'h0), 2'h0, 4'(n), 8'h1A});
      pulse(3'h1);
      exp = ((16'h1 << n) & 16'hFFFE) | {15'h0, n == 15};
      check(o_flags, exp, "flag select");
      check(o_fetch_req, 1'b1, "next command");
      apb(1'b1, ADDR_FLAGS, 32'hFFFF);
    end
    apb(1'b0, ADDR_LIST_END_INFO, 32'h0);
    check(rdata, 32'h40, "buffer bit");
    $display("test flag select done");
  endtask

  task automatic t_error;
    load(16'h0005);
    pulse(3'h4);
    check(o_cmd_error, 1'b1, "reserved channel");
    check(o_fetch_req, 1'b0, "halted");
    apb(1'b1, ADDR_CONTROL, 32'h3);
    apb(1'b0, ADDR_LIST_END_INFO, 32'h0);
    check(rdata, 32'h0, "soft reset clears info");
    check(o_cmd_error, 1'b0, "soft reset clears error");
    apb(1'b1, ADDR_CONTROL, 32'h1);
    $display("test error done");
  endtask

  task automatic t_restart;
    apb(1'b1, ADDR_CONTROL, 32'h9);
    pulse(3'h4);
    load(16'hC002);
    check(o_channel_sel, 6'h02, "midpoint channel");
    pulse(3'h1);
    check({o_list_wrap, o_fetch_req}, 2'h2, "wrap and wait");
    check(o_flags, 16'h0001, "list end flag only");
    pulse(3'h4);
    check(o_fetch_req, 1'b0, "trigger before restart");
    pulse(3'h2);
    check(o_fetch_req, 1'b0, "restart arms only");
    pulse(3'h4);
    check(o_fetch_req, 1'b1, "trigger after restart");
    apb(1'b1, ADDR_CONTROL, 32'h1);
    load(16'hC002);
    pulse(3'h1);
    pulse(3'h2);
    check({o_list_wrap, o_fetch_req}, 2'h3, "trigger mode restart");
    apb(1'b1, ADDR_FLAGS, 32'h1);
    $display("test restart done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    repeat (4) step;
    i_reset <= 1'b0;
    step;
    t_regs;
    t_cmd_access;
    t_freeze;
    t_list_end;
    t_flag_sel;
    t_error;
    t_restart;
    tally_and_finish;
  end

  initial begin
    repeat (5000) step;
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule
